// [design/cbt_top.sv]
// CAN bit timing logic with synchronisation and an APB register slave.
// Assumes I_RX is synchronous to I_CORE_CLK; 0 is dominant.
`timescale 1ns/100ps
module cbt_top
    import cbt_pkg::*;
(
    input  wire logic        I_CORE_CLK,   // Core clock
    input  wire logic        I_RESETN,     // Async reset, active low
    input  wire logic        I_PSEL,       // APB select
    input  wire logic        I_PENABLE,    // APB access phase
    input  wire logic        I_PWRITE,     // APB direction
    input  wire logic [7:0]  I_PADDR,      // APB byte address
    input  wire logic [31:0] I_PWDATA,     // APB write data
    output logic      [31:0] O_PRDATA,     // APB read data
    output logic             O_PREADY,     // APB ready
    output logic             O_PSLVERR,    // APB error
    input  wire logic        I_RX,         // Received bus level
    input  wire logic        I_BUS_IDLE,   // Controller: bus idle, hard sync ok
    output logic             O_SAMPLE,     // Sample point strobe
    output logic             O_SAMPLE_BIT, // Bit taken at sample point
    output logic             O_HARD_SYNC,  // Hard sync done, pulse
    output logic             O_RESYNC      // Resync done, pulse
);

    logic [31:0] timing_q;     // Timing register
    logic [31:0] ctrl_q;       // Control register
    logic [4:0]  brp_cnt_q;    // Prescaler count
    logic        tq_en;        // One quantum enable pulse
    cbt_phase_e  phase_q;      // Current bit segment
    logic [4:0]  cnt_q;        // Quanta done in segment
    logic [4:0]  tseg1_len_q;  // Current TSEG1 length
    logic        prev_smp_q;   // Bus level at previous sample point
    logic        synced_q;     // Synchronised since last sample point
    logic        smp_q;        // Sample strobe register
    logic        bit_q;        // Sampled bit
    logic        hs_q;         // Hard sync pulse
    logic        rs_q;         // Resync pulse
    logic        sync_edge;    // Qualifying edge this quantum
    logic        hard;         // Use hard sync
    logic [4:0]  sjw;          // Functional SJW
    logic [4:0]  ps2;          // Functional Phase_Seg2
    logic [4:0]  tseg1_nom;    // Nominal Prop_Seg plus Phase_Seg1
    logic [4:0]  rem2;         // Quanta left in Phase_Seg2
    logic        acc;          // APB access phase
    logic        hit;          // Mapped address

    // How a bit is built here
    // A bit is Sync_Seg, then TSEG1 (Prop_Seg plus Phase_Seg1), then
    // Phase_Seg2. The sample point sits at the end of TSEG1, so the state
    // machine sees each bit as running from one sample point to the next.
    // Every step of the machine is one time quantum, given by tq_en.
    //
    // Edge detection
    // The bus level of each quantum is held against the level taken at
    // the last sample point. Only a recessive sample followed by a
    // dominant quantum counts as an edge. Rising edges never count.
    // After the first counted edge synced_q blocks any further edge
    // until the next sample point clears it.
    //
    // Phase error
    // An edge inside TSEG1 is late: its error is the number of quanta
    // since the end of Sync_Seg, counting the edge quantum itself.
    // An edge inside Phase_Seg2 is early: its error is the number of
    // quanta left up to the next Sync_Seg, the edge quantum included.
    // An edge inside Sync_Seg has no error and moves nothing.
    //
    // Corrections
    // Late edges lengthen TSEG1 by the error, capped at SJW.
    // Early edges cut Phase_Seg2 by the error, capped at SJW. When the
    // cut reaches the edge quantum the Sync_Seg quantum is skipped, since
    // the edge quantum itself serves as the Sync_Seg.
    // Every correction is undone when the next Sync_Seg begins.
    //
    // Limits a user must know
    // SJW larger than a phase segment is not checked by the logic; the
    // configuring software must keep it within both segments.
    // Timing fields are taken at once, so a change in mid-bit can give
    // one odd bit. Change them while the block is disabled if that
    // matters.

    // Extract a 3-bit field as functional length
    function automatic logic [4:0] fld3(input logic [31:0] r,
                                        input int lsb);
        fld3 = {2'h0, r[lsb +: 3]} + 5'h01;
    endfunction

    // Smaller of two quanta counts
    function automatic logic [4:0] min5(input logic [4:0] a,
                                        input logic [4:0] b);
        min5 = (a < b) ? a : b;
    endfunction

    assign sjw       = {3'h0, timing_q[CBT_SJW_LSB +: 2]} + 5'h01;
    assign ps2       = fld3(timing_q, CBT_PS2_LSB);
    assign tseg1_nom = fld3(timing_q, CBT_PROP_LSB)
                     + fld3(timing_q, CBT_PS1_LSB);
    assign rem2      = ps2 - cnt_q;
    // Falling edge against last sample, once per bit
    assign sync_edge = tq_en && prev_smp_q && !I_RX
                     && !synced_q;
    assign hard      = ctrl_q[CBT_HARD_BIT] && I_BUS_IDLE;

    // APB slave, zero wait states
    // Ready is tied high: every access ends in its first access cycle.
    // Unmapped addresses answer with an error and read as zero, and a
    // write to them changes nothing.
    assign acc       = I_PSEL && I_PENABLE;
    assign hit       = (I_PADDR == CBT_OFF_TIMING) || (I_PADDR == CBT_OFF_CTRL)
                     || (I_PADDR == CBT_OFF_STATUS);
    assign O_PREADY  = 1'b1;
    assign O_PSLVERR = acc && !hit;

    // Register writes
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            timing_q <= CBT_TIMING_RST;
            ctrl_q   <= CBT_CTRL_RST;
        end else if (acc && I_PWRITE) begin
            if (I_PADDR == CBT_OFF_TIMING) begin
                timing_q <= I_PWDATA & 32'h0033_771f;
            end else if (I_PADDR == CBT_OFF_CTRL) begin
                ctrl_q <= I_PWDATA & 32'h0000_0003;
            end
        end else if (hs_q) begin
            ctrl_q[CBT_HARD_BIT] <= 1'b0; // One hard sync per frame start
        end
    end

    // Read data register
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            O_PRDATA <= 32'h0;
        end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            case (I_PADDR)
                CBT_OFF_TIMING: O_PRDATA <= timing_q;
                CBT_OFF_CTRL:   O_PRDATA <= ctrl_q;
                CBT_OFF_STATUS: O_PRDATA <= {16'h0, 3'h0, tseg1_len_q,
                                             2'h0, phase_q, 1'b0,
                                             synced_q, prev_smp_q, bit_q};
                default:        O_PRDATA <= 32'h0;
            endcase
        end
    end

    // Prescaler: one pulse every BRP+1 clocks
    // The counter rests at zero while the block is disabled, so the
    // first quantum after enable is a full one.
    // The compare is an equality: lowering BRP while the count is above
    // the new value would wrap once, so change it while disabled.
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            brp_cnt_q <= 5'h0;
        end else if (!ctrl_q[CBT_EN_BIT] || tq_en) begin
            brp_cnt_q <= 5'h0;
        end else begin
            brp_cnt_q <= brp_cnt_q + 5'h01;
        end
    end
    assign tq_en = ctrl_q[CBT_EN_BIT]
                && (brp_cnt_q == timing_q[CBT_BRP_LSB +: 5]);

    // Bit timing state machine, one step per quantum
    // The sync branches come first: a hard sync edge, or a qualifying edge in TSEG1
    // or Phase_Seg2, wins over the plain segment count of the same quantum.
    // Hard sync restarts the bit whatever the phase of the edge.
    // A late edge keeps counting TSEG1 but with a longer target length.
    // An early edge either jumps straight into TSEG1, or moves the
    // Phase_Seg2 count on by SJW, or ends Phase_Seg2 at the edge quantum.
    // cnt_q holds the quanta already spent in the current segment,
    // not counting the quantum being processed; after an early edge that only shortens Phase_Seg2 it is SJW higher.
    // Pulse outputs are cleared each clock and set for a single cycle.
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            phase_q     <= CBT_SYNC;
            cnt_q       <= 5'h0;
            tseg1_len_q <= 5'h02;
            prev_smp_q  <= 1'b1;
            synced_q    <= 1'b0;
            smp_q       <= 1'b0;
            bit_q       <= 1'b1;
            hs_q        <= 1'b0;
            rs_q        <= 1'b0;
        end else begin
            smp_q <= 1'b0;
            hs_q  <= 1'b0;
            rs_q  <= 1'b0;
            if (sync_edge && hard) begin
                // Edge quantum becomes Sync_Seg; TSEG1 follows
                phase_q     <= CBT_TSEG1;
                cnt_q       <= 5'h0;
                tseg1_len_q <= tseg1_nom;
                synced_q    <= 1'b1;
                hs_q        <= 1'b1;
            end else if (sync_edge && phase_q == CBT_TSEG1) begin
                // Late edge: lengthen Phase_Seg1 up to SJW
                tseg1_len_q <= tseg1_nom
                             + min5(cnt_q + 5'h01, sjw);
                cnt_q       <= cnt_q + 5'h01;
                synced_q    <= 1'b1;
                rs_q        <= 1'b1;
            end else if (sync_edge && phase_q == CBT_TSEG2) begin
                synced_q <= 1'b1;
                rs_q     <= 1'b1;
                if (rem2 <= sjw) begin
                    // Early edge absorbed: skip Sync_Seg, go to TSEG1
                    phase_q     <= CBT_TSEG1;
                    cnt_q       <= 5'h0;
                    tseg1_len_q <= tseg1_nom;
                end else if (rem2 == sjw + 5'h01) begin
                    // Cut by SJW ends Phase_Seg2 on the edge quantum
                    phase_q     <= CBT_SYNC;
                    cnt_q       <= 5'h0;
                    tseg1_len_q <= tseg1_nom;
                end else begin
                    // Shorten Phase_Seg2 by SJW only
                    cnt_q <= cnt_q + sjw + 5'h01;
                end
            end else if (tq_en) begin
                if (sync_edge) begin
                    synced_q <= 1'b1;
                end
                case (phase_q)
                    CBT_SYNC: begin
                        if (cnt_q + 5'h01 >= CBT_SYNC_TQ) begin
                            phase_q <= CBT_TSEG1;
                            cnt_q   <= 5'h0;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    CBT_TSEG1: begin
                        if (cnt_q + 5'h01 >= tseg1_len_q) begin
                            // Sample point: bit period boundary
                            phase_q    <= CBT_TSEG2;
                            cnt_q      <= 5'h0;
                            smp_q      <= 1'b1;
                            bit_q      <= I_RX;
                            prev_smp_q <= I_RX;
                            synced_q   <= 1'b0;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    CBT_TSEG2: begin
                        if (cnt_q + 5'h01 >= ps2) begin
                            phase_q     <= CBT_SYNC;
                            cnt_q       <= 5'h0;
                            tseg1_len_q <= tseg1_nom;
                        end else begin
                            cnt_q <= cnt_q + 5'h01;
                        end
                    end
                    default: begin
                        phase_q <= CBT_SYNC;
                        cnt_q   <= 5'h0;
                    end
                endcase
            end
        end
    end

    assign O_SAMPLE     = smp_q;
    assign O_SAMPLE_BIT = bit_q;
    assign O_HARD_SYNC  = hs_q;
    assign O_RESYNC     = rs_q;

endmodule // cbt_top

// [pkg/cbt_pkg.sv]
// Package for the CAN bit timing and synchronisation block.
// Assumes a single core clock; register offsets are APB byte addresses.
package cbt_pkg;
    // Register byte offsets
    localparam logic [7:0] CBT_OFF_TIMING = 8'h00; // Segment lengths
    localparam logic [7:0] CBT_OFF_CTRL   = 8'h04; // Enable and hard-sync arm
    localparam logic [7:0] CBT_OFF_STATUS = 8'h08; // Bit timing state
    // Timing register field positions (values stored minus one)
    localparam int CBT_BRP_LSB  = 0;  // Prescaler, 5 bits
    localparam int CBT_PROP_LSB = 8;  // Prop_Seg, 3 bits
    localparam int CBT_PS1_LSB  = 12; // Phase_Seg1, 3 bits
    localparam int CBT_PS2_LSB  = 16; // Phase_Seg2, 3 bits read, writes keep only the low 2
    localparam int CBT_SJW_LSB  = 20; // SJW, 2 bits
    // Control register field positions
    localparam int CBT_EN_BIT   = 0;  // Block enable
    localparam int CBT_HARD_BIT = 1;  // Arm hard sync for next frame start
    // Reset values
    localparam logic [31:0] CBT_TIMING_RST = 32'h0033_3100;
    localparam logic [31:0] CBT_CTRL_RST   = 32'h0000_0002;
    // Fixed length of Sync_Seg in quanta
    localparam logic [4:0]  CBT_SYNC_TQ    = 5'h01;
    // Bit timing phases
    typedef enum logic [1:0] {CBT_SYNC, CBT_TSEG1, CBT_TSEG2} cbt_phase_e;
endpackage

// [dv/cbt_top_sva.sv]
// Checker for the bit timing block: strobe and sync relations.
// Assumes a bind into cbt_top and a single core clock domain.
`timescale 1ns/100ps
module cbt_top_sva (
    input wire logic I_CORE_CLK,   // Core clock
    input wire logic I_RESETN,     // Reset, active low
    input wire logic I_PSEL,       // APB select
    input wire logic I_PENABLE,    // APB access phase
    input wire logic I_RX,         // Bus level
    input wire logic I_BUS_IDLE,   // Hard sync allowed
    input wire logic O_PSLVERR,    // APB error
    input wire logic O_SAMPLE,     // Sample strobe
    input wire logic O_SAMPLE_BIT, // Sampled bit
    input wire logic O_HARD_SYNC,  // Hard sync pulse
    input wire logic O_RESYNC      // Resync pulse
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESETN);
    wire sync = O_HARD_SYNC | O_RESYNC; // Any sync pulse
    // Sync that opens a new interval
    sequence s_sync; sync && !O_SAMPLE; endsequence
    // Next sample point, bounded by the longest bit
    sequence s_next; ##[1:1000] O_SAMPLE; endsequence
    property p_strobe; O_SAMPLE |=> !O_SAMPLE; endproperty
    property p_hold; $changed(O_SAMPLE_BIT) |-> O_SAMPLE; endproperty
    property p_edge; sync |-> !$past(I_RX) && $past(O_SAMPLE_BIT); endproperty
    property p_kind; !(O_HARD_SYNC && O_RESYNC); endproperty
    property p_hard; O_HARD_SYNC |-> $past(I_BUS_IDLE); endproperty
    property p_once; s_sync |=> !sync until_with O_SAMPLE; endproperty
    property p_bound; s_sync |-> s_next; endproperty
    property p_err; O_PSLVERR |-> I_PSEL && I_PENABLE; endproperty
    a_strobe: assert property (p_strobe)
        else $error("sample strobe longer than one cycle");
    a_hold: assert property (p_hold)
        else $error("sampled bit moved off the sample point");
    a_edge: assert property (p_edge)
        else $error("sync without a recessive to dominant edge");
    a_kind: assert property (p_kind)
        else $error("hard sync and resync together");
    a_hard: assert property (p_hard)
        else $error("hard sync outside frame start");
    a_once: assert property (p_once)
        else $error("second sync before the sample point");
    a_bound: assert property (p_bound)
        else $error("no sample point after a sync");
    a_err: assert property (p_err)
        else $error("error outside an access phase");
endmodule // cbt_top_sva
bind cbt_top cbt_top_sva u_cbt_top_sva (.I_CORE_CLK(I_CORE_CLK),
    .I_RESETN(I_RESETN), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_RX(I_RX), .I_BUS_IDLE(I_BUS_IDLE), .O_PSLVERR(O_PSLVERR),
    .O_SAMPLE(O_SAMPLE), .O_SAMPLE_BIT(O_SAMPLE_BIT),
    .O_HARD_SYNC(O_HARD_SYNC), .O_RESYNC(O_RESYNC));

// [dv/cbt_bus_model.sv]
// Bus model: a transceiver output that idles recessive.
// Assumes the caller times its pulses in core clocks.
`timescale 1ns/100ps
module cbt_bus_model (
    input  wire logic i_clk, // Core clock
    output logic      o_rx   // Bus level, 0 is dominant
);
    initial o_rx = 1'b1; // Idle bus is recessive
    // Dominant pulse w clocks long, d clocks from now, no drift
    task spike(input int d, input int w);
        if (w > 0) begin
            repeat (d) @(posedge i_clk);
            o_rx <= 1'b0;
            repeat (w) @(posedge i_clk);
            o_rx <= 1'b1;
        end
    endtask
endmodule // cbt_bus_model

// [dv/cbt_top_bench.sv]
// Bench for cbt_top: APB access and bit sync on a modelled bus.
// Assumes one quantum per clock unless the prescaler is raised.
`timescale 1ns/100ps
module cbt_top_bench;
    import cbt_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, idle = 1'b0;   // Clock, reset
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;     // APB drives
    logic [7:0]  paddr = 8'h00;                           // APB address
    logic [31:0] pwdata = 32'h0, rd, prdata;              // APB data
    logic        rdy, err, er, rx, smp, sbit, hs, rs, h;  // Observed
    int          n_mismatch = 0, compares = 0, p, s;      // Results
    always #20 clk = ~clk; // 25 MHz
    cbt_bus_model u_cbt_bus_model (.i_clk(clk), .o_rx(rx));
    cbt_top u_cbt_top (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(rdy), .O_PSLVERR(err), .I_RX(rx),
        .I_BUS_IDLE(idle), .O_SAMPLE(smp), .O_SAMPLE_BIT(sbit),
        .O_HARD_SYNC(hs), .O_RESYNC(rs));
    // Compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("Error %s exp %h got %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    // One APB transfer, held until ready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1 && n++ < 50);
        if (rdy !== 1'b1) n_mismatch++;
        rd = prdata;
        er = err;
        {psel, pen} <= 2'b00;
    endtask
    // Read and compare
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // Wait for a strobe, pulse the bus, time the next bit and its sync
    task run_bit(input int d, input int w);
        int n, t;
        n = 0;
        t = 0;
        h = 1'b0;
        do @(posedge clk); while (smp !== 1'b1 && n++ < 100);
        n = 0;
        fork u_cbt_bus_model.spike(d, w); join_none
        do begin
            @(posedge clk);
            n++;
            if (rs === 1'b1 || hs === 1'b1) begin
                t = n;
                h = hs;
            end
        end while (smp !== 1'b1 && n < 200);
        p = n;
        s = n - t;
    endtask
    // Verdict and end of run
    task end_of_test;
        $display("Compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #(40 * 4000);
        n_mismatch++;
        end_of_test();
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rdc("timing", CBT_OFF_TIMING, CBT_TIMING_RST);
        rdc("ctrl", CBT_OFF_CTRL, CBT_CTRL_RST);
        rdc("unmapped", 8'h0c, 32'h0);
        chk("slverr", 32'h1, {31'h0, er});
        $display("Registers done");
        apb(1'b1, CBT_OFF_TIMING, 32'h0033_3000);
        rdc("timing back", CBT_OFF_TIMING, 32'h0033_3000);
        idle <= 1'b1;
        apb(1'b1, CBT_OFF_CTRL, 32'h3);
        run_bit(6, 2);
        chk("hard", 32'h1, {31'h0, h});
        chk("hard dist", 32'd5, s);
        chk("spike", 32'h1, {31'h0, sbit});
        rdc("ctrl clear", CBT_OFF_CTRL, 32'h1);
        run_bit(6, 2);
        chk("not hard", 32'h0, {31'h0, h});
        chk("late", 32'd5, s);
        run_bit(1, 2);
        chk("early", 32'd5, s);
        run_bit(0, 0);
        chk("nominal", 32'd10, p);
        $display("Full jump width done");
        apb(1'b1, CBT_OFF_TIMING, 32'h0003_3000);
        run_bit(6, 2);
        chk("late cap", 32'd11, p);
        run_bit(0, 0);
        chk("restore", 32'd10, p);
        run_bit(1, 2);
        chk("early cap", 32'd9, p);
        apb(1'b1, CBT_OFF_TIMING, 32'h0003_3201);
        run_bit(0, 0);
        run_bit(0, 0);
        chk("prescaled", 32'd24, p);
        $display("Single jump width done");
        end_of_test();
    end
endmodule // cbt_top_bench
